//--- pio_pkg.sv
// Package: register addresses, reset values and widths of the port I/O block
package pio_pkg;
    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] PIO_ADDR_P0_DATA = 8'h80;
    localparam logic [7:0] PIO_ADDR_P1_DATA = 8'h90;
    localparam logic [7:0] PIO_ADDR_P0_OTYPE = 8'ha4;
    localparam logic [7:0] PIO_ADDR_P0_BYPASS = 8'hd4;
    localparam logic [7:0] PIO_ADDR_P0_ASEL = 8'hf1;
    localparam logic [7:0] PIO_ADDR_P1_ASEL = 8'hf2;
    localparam logic [7:0] PIO_ADDR_P1_OTYPE = 8'ha5;
    localparam logic [7:0] PIO_ADDR_XBAR_CTL = 8'he2;
    // ****************************************
    // Reset values and field positions
    // ****************************************
    localparam logic [7:0] PIO_RST_DATA = 8'hff;
    localparam logic [7:0] PIO_RST_OTYPE = 8'h00;
    localparam logic [7:0] PIO_RST_BYPASS = 8'h00;
    localparam logic [7:0] PIO_RST_ASEL = 8'hff;
    localparam logic [7:0] PIO_RST_XBAR = 8'h00;
    localparam int PIO_XBAR_EN_BIT = 6;
    localparam int PIO_WIDTH = 8;
endpackage : pio_pkg

//--- pio_pin_cell.sv
// Per-port pin cell: synchroniser, readback and driver control
`timescale 1ns/10ps
`default_nettype none
module pio_pin_cell #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Configuration
    input wire logic [WIDTH-1:0] latch,
    input wire logic [WIDTH-1:0] analog_sel,
    input wire logic [WIDTH-1:0] output_type,
    input wire logic [WIDTH-1:0] periph_own,
    input wire logic [WIDTH-1:0] periph_out,
    input wire logic [WIDTH-1:0] periph_oe,
    input wire logic xbar_en,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pull_en,
    // Readback
    output logic [WIDTH-1:0] pin_level
);
    logic [WIDTH-1:0] sync_a;
    logic [WIDTH-1:0] sync_b;

    // Elaboration check: the readback path serves one byte at most
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("pio_pin_cell: WIDTH must be 1..8");
    end

    // Two-stage synchroniser on the pad inputs
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            logic drv_val;
            // Peripheral takes the pin when routed, otherwise the latch drives it
            assign drv_val = periph_own[i] ? periph_out[i] : latch[i];
            // Latch low always driven; latch high only when push-pull; routed pins follow periph_oe; analog or crossbar off kills driver
            assign pin_oe[i] = xbar_en && analog_sel[i] &&
                (periph_own[i] ? periph_oe[i] : (!drv_val || output_type[i]));
            assign pin_out[i] = drv_val;
            // Pull-up off for analog pins
            assign pull_en[i] = analog_sel[i];
            // Analog pins read one, digital pins read the pad level
            assign pin_level[i] = analog_sel[i] ? sync_b[i] : 1'b1;
        end
    endgenerate
endmodule : pio_pin_cell
`default_nettype wire

//--- pio_port_io.sv
// Port 0 and Port 1 general-purpose I/O: latches, mode registers and SFR access
// Contract
// - Pins not taken by crossbar or analog act as software-controlled GPIO.
// - Port data registers accessible as whole byte and as single bits.
// - Writes to port data go to an output latch that keeps driving.
// - Plain reads return live pin levels, even for crossbar-routed pins.
// - Read-modify-write instructions read the latch, not the pins.
// - ANL ORL XRL JBC CPL INC DEC DJNZ on a port are read-modify-write.
// - Bit move, clear and set on a port bit use latch reads too.
// - Latch 0 drives low; latch 1 drives high unless open-drain.
// - A pin set as analog input reads back as 1.
// - A digital input pin reads its pad level directly; here it is read through the two-stage synchroniser.
// - Output-type bit 0 means open-drain, 1 means push-pull.
// - Output-type bit ignored while the pin's analog-select bit is 0.
// - Analog-select 0 disables pull-up, driver and receiver of the pin.
// - All port drivers stay off while the crossbar is disabled.
`timescale 1ns/10ps
`default_nettype none
module pio_port_io (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // SFR access from the core
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_bit,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_rmw,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Crossbar side
    input wire logic [7:0] p0_periph_own,
    input wire logic [7:0] p0_periph_out,
    input wire logic [7:0] p0_periph_oe,
    input wire logic [7:0] p1_periph_own,
    input wire logic [7:0] p1_periph_out,
    input wire logic [7:0] p1_periph_oe,
    output logic [7:0] p0_skip,
    output logic [7:0] p1_analog,
    output logic [7:0] p0_analog,
    output logic crossbar_global_enable,
    // Port 0 pins
    input wire logic [7:0] p0_pin_in,
    output logic [7:0] p0_pin_out,
    output logic [7:0] p0_pin_oe,
    output logic [7:0] p0_pull_en,
    // Port 1 pins
    input wire logic [7:0] p1_pin_in,
    output logic [7:0] p1_pin_out,
    output logic [7:0] p1_pin_oe,
    output logic [7:0] p1_pull_en
);
    import pio_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] port_zero_data;
    logic [7:0] port_one_data;
    logic [7:0] port_zero_output_type;
    logic [7:0] port_one_output_type;
    logic [7:0] port_zero_crossbar_bypass;
    logic [7:0] port_zero_analog_select;
    logic [7:0] port_one_analog_select;
    logic [7:0] crossbar_ctl;
    logic [7:0] p0_level;
    logic [7:0] p1_level;
    logic [7:0] cur_val;
    logic [7:0] lat_val;
    logic [7:0] next_val;

    // Merge a single-bit write into the byte that was read
    function automatic logic [7:0] pio_merge(input logic [7:0] base, input logic bit_mode,
                                             input logic [2:0] sel, input logic [7:0] wdata);
        logic [7:0] res;
        res = base;
        if (bit_mode) begin
            res[sel] = wdata[0];
        end else begin
            res = wdata;
        end
        return res;
    endfunction : pio_merge

    // Byte seen by the current access: latch for RMW, pins otherwise
    always_comb begin
        cur_val = 8'h00;
        if (sfr_addr == PIO_ADDR_P0_DATA) begin
            cur_val = sfr_rmw ? port_zero_data : p0_level;
        end else if (sfr_addr == PIO_ADDR_P1_DATA) begin
            cur_val = sfr_rmw ? port_one_data : p1_level;
        end else if (sfr_addr == PIO_ADDR_P0_OTYPE) begin
            cur_val = port_zero_output_type;
        end else if (sfr_addr == PIO_ADDR_P1_OTYPE) begin
            cur_val = port_one_output_type;
        end else if (sfr_addr == PIO_ADDR_P0_BYPASS) begin
            cur_val = port_zero_crossbar_bypass;
        end else if (sfr_addr == PIO_ADDR_P0_ASEL) begin
            cur_val = port_zero_analog_select;
        end else if (sfr_addr == PIO_ADDR_P1_ASEL) begin
            cur_val = port_one_analog_select;
        end else if (sfr_addr == PIO_ADDR_XBAR_CTL) begin
            cur_val = crossbar_ctl;
        end
    end

    // Bit writes to port data always start from the latch, never the pins
    // A process, not a function call, so latch changes retrigger the merge
    always_comb begin
        lat_val = cur_val;
        if (sfr_addr == PIO_ADDR_P0_DATA) begin
            lat_val = port_zero_data;
        end else if (sfr_addr == PIO_ADDR_P1_DATA) begin
            lat_val = port_one_data;
        end
    end

    // Bit writes merge into the latch-read byte, so other latch bits are kept
    assign next_val = pio_merge((sfr_rmw || sfr_bit) ? lat_val : cur_val,
                                sfr_bit, sfr_bit_sel, sfr_wdata);

    // Port data latches
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port_zero_data <= PIO_RST_DATA;
            port_one_data <= PIO_RST_DATA;
        end else if (sfr_wr) begin
            if (sfr_addr == PIO_ADDR_P0_DATA) begin
                port_zero_data <= next_val;
            end else if (sfr_addr == PIO_ADDR_P1_DATA) begin
                port_one_data <= next_val;
            end
        end
    end

    // Mode registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port_zero_output_type <= PIO_RST_OTYPE;
            port_one_output_type <= PIO_RST_OTYPE;
            port_zero_crossbar_bypass <= PIO_RST_BYPASS;
            port_zero_analog_select <= PIO_RST_ASEL;
            port_one_analog_select <= PIO_RST_ASEL;
            crossbar_ctl <= PIO_RST_XBAR;
        end else if (sfr_wr) begin
            if (sfr_addr == PIO_ADDR_P0_OTYPE) begin
                port_zero_output_type <= next_val;
            end else if (sfr_addr == PIO_ADDR_P1_OTYPE) begin
                port_one_output_type <= next_val;
            end else if (sfr_addr == PIO_ADDR_P0_BYPASS) begin
                port_zero_crossbar_bypass <= next_val;
            end else if (sfr_addr == PIO_ADDR_P0_ASEL) begin
                port_zero_analog_select <= next_val;
            end else if (sfr_addr == PIO_ADDR_P1_ASEL) begin
                port_one_analog_select <= next_val;
            end else if (sfr_addr == PIO_ADDR_XBAR_CTL) begin
                crossbar_ctl <= next_val;
            end
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= sfr_bit ? {7'h00, cur_val[sfr_bit_sel]} : cur_val;
        end
    end

    // Crossbar-facing controls
    assign p0_skip = port_zero_crossbar_bypass;
    assign p0_analog = port_zero_analog_select;
    assign p1_analog = port_one_analog_select;
    assign crossbar_global_enable = crossbar_ctl[PIO_XBAR_EN_BIT];

    // ****************************************
    // Pin cells
    // ****************************************
    pio_pin_cell #(.WIDTH(PIO_WIDTH)) u_port0 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .latch(port_zero_data),
        .analog_sel(port_zero_analog_select),
        .output_type(port_zero_output_type),
        .periph_own(p0_periph_own),
        .periph_out(p0_periph_out),
        .periph_oe(p0_periph_oe),
        .xbar_en(crossbar_global_enable),
        .pin_in(p0_pin_in),
        .pin_out(p0_pin_out),
        .pin_oe(p0_pin_oe),
        .pull_en(p0_pull_en),
        .pin_level(p0_level)
    );

    pio_pin_cell #(.WIDTH(PIO_WIDTH)) u_port1 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .latch(port_one_data),
        .analog_sel(port_one_analog_select),
        .output_type(port_one_output_type),
        .periph_own(p1_periph_own),
        .periph_out(p1_periph_out),
        .periph_oe(p1_periph_oe),
        .xbar_en(crossbar_global_enable),
        .pin_in(p1_pin_in),
        .pin_out(p1_pin_out),
        .pin_oe(p1_pin_oe),
        .pull_en(p1_pull_en),
        .pin_level(p1_level)
    );
endmodule : pio_port_io
`default_nettype wire

//--- pio_props.sv
// Checker: port I/O assertions and covers
`timescale 1ns/10ps
`default_nettype none
module pio_props import pio_pkg::*; (
    // Clock, reset and SFR side
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_bit,
    input wire logic sfr_rmw,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Crossbar side and pins
    input wire logic [7:0] p0_periph_own,
    input wire logic [7:0] p0_skip,
    input wire logic [7:0] p0_analog,
    input wire logic crossbar_global_enable,
    input wire logic [7:0] p0_pin_out,
    input wire logic [7:0] p0_pin_oe,
    input wire logic [7:0] p0_pull_en,
    input wire logic [7:0] p1_pin_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic p0w;
    logic p0r;
    // Byte accesses to the port 0 data register
    assign p0w = sfr_wr && !sfr_bit && sfr_addr == PIO_ADDR_P0_DATA;
    assign p0r = sfr_rd && !sfr_bit && !sfr_wr && sfr_addr == PIO_ADDR_P0_DATA;
    a_oe_xbar_off: assert property (!crossbar_global_enable |-> (p0_pin_oe | p1_pin_oe) == 8'h00)
        else $error("driver on with crossbar off");
    a_pull_asel: assert property (p0_pull_en == p0_analog)
        else $error("pull-up not following analog select");
    a_analog_no_drive: assert property ((p0_pin_oe & ~p0_analog) == 8'h00)
        else $error("analog pin driven");
    a_bit_read_zero: assert property (sfr_rd && sfr_bit |=> sfr_rdata[7:1] == 7'h00)
        else $error("bit read upper bits set");
    a_analog_reads_one: assert property (p0r && !sfr_rmw |=> (sfr_rdata | $past(p0_analog)) == 8'hff)
        else $error("analog pin read as 0");
    a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without read");
    a_latch_drive: assert property (p0w && p0_periph_own == 8'h00 && crossbar_global_enable && p0_analog == 8'hff
        |=> p0_pin_out == $past(sfr_wdata) && (~p0_pin_oe & ~p0_pin_out) == 8'h00)
        else $error("latch not driving pins");
    a_rmw_latch: assert property (p0w ##1 !sfr_wr ##1 p0r && sfr_rmw |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("rmw read not latch");
    a_skip_write: assert property (sfr_wr && !sfr_bit && sfr_addr == PIO_ADDR_P0_BYPASS |=> p0_skip == $past(sfr_wdata))
        else $error("bypass write lost");
    c_rmw: cover property (p0r && sfr_rmw);
    c_analog: cover property (p0r && p0_analog != 8'hff);
    c_xbar_off: cover property ($fell(crossbar_global_enable));
endmodule : pio_props
bind pio_port_io pio_props i_props (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_bit(sfr_bit), .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .p0_periph_own(p0_periph_own), .p0_skip(p0_skip), .p0_analog(p0_analog), .p1_pin_oe(p1_pin_oe),
    .crossbar_global_enable(crossbar_global_enable), .p0_pin_out(p0_pin_out), .p0_pin_oe(p0_pin_oe),
    .p0_pull_en(p0_pull_en));
`default_nettype wire

//--- pio_board.sv
// Board model: pad wiring with pull-ups and outside drivers
`timescale 1ns/10ps
`default_nettype none
module pio_board (
    // Clock
    input wire logic clk_sys,
    // Pad side of the block
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_en,
    // Outside drivers
    input wire logic [7:0] ext_oe,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    logic [7:0] flt = 8'h55;
    // Floating pads wander so a stale level never reads as valid
    always @(posedge clk_sys) flt <= ~flt;
    // Block driver first, then outside driver, then weak pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe & (pull_en | flt));
endmodule : pio_board
`default_nettype wire

//--- pio_port_io_tb.sv
// Testbench: port latch, readback and mode scenarios
`timescale 1ns/10ps
`default_nettype none
module pio_port_io_tb;
    import pio_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit = 1'b0, sfr_rmw = 1'b0;
    logic [2:0] sfr_bit_sel = 3'h0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, own = 8'h00, pout = 8'h00, poe = 8'h00, ext_oe = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] sfr_rdata, p0_skip, p1_an, p0_an, p0_in, p0_out, p0_oe, p0_pu, p1_in, p1_out, p1_oe, p1_pu;
    logic xbar;
    int mismatches = 0, n_checks = 0, cycles = 0;
    // ****************************************
    // Clock, watchdog and instances
    // ****************************************
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            stop_test();
        end
    end
    pio_port_io i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_bit(sfr_bit), .sfr_bit_sel(sfr_bit_sel), .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .p0_periph_own(own), .p0_periph_out(pout), .p0_periph_oe(poe), .p1_periph_own(8'h00), .p1_periph_out(8'h00),
        .p1_periph_oe(8'h00), .p0_skip(p0_skip), .p1_analog(p1_an), .p0_analog(p0_an), .crossbar_global_enable(xbar),
        .p0_pin_in(p0_in), .p0_pin_out(p0_out), .p0_pin_oe(p0_oe), .p0_pull_en(p0_pu),
        .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe), .p1_pull_en(p1_pu));
    pio_board i_b0 (.clk_sys(clk_sys), .pin_out(p0_out), .pin_oe(p0_oe), .pull_en(p0_pu), .ext_oe(ext_oe),
        .ext_val(ext_val), .pin_in(p0_in));
    pio_board i_b1 (.clk_sys(clk_sys), .pin_out(p1_out), .pin_oe(p1_oe), .pull_en(p1_pu), .ext_oe(8'h00),
        .ext_val(8'h00), .pin_in(p1_in));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One SFR cycle; read data is settled when it returns
    task automatic acc(input logic wr, input logic [7:0] a, d, input logic b, input logic [2:0] s, input logic m);
        @(posedge clk_sys);
        {sfr_wr, sfr_rd, sfr_bit, sfr_rmw} <= {wr, !wr, b, m};
        {sfr_addr, sfr_wdata, sfr_bit_sel} <= {a, d, s};
        @(posedge clk_sys);
        {sfr_wr, sfr_rd} <= 2'b00;
        #1;
    endtask : acc
    task automatic w(input logic [7:0] a, d);
        acc(1'b1, a, d, 1'b0, 3'h0, 1'b0);
    endtask : w
    task automatic r(input string n, input logic [7:0] a, input logic m, input logic [7:0] e);
        acc(1'b0, a, 8'h00, 1'b0, 3'h0, m);
        chk(n, sfr_rdata, e);
    endtask : r
    // Let pad changes cross the synchroniser
    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask : settle
    task automatic t_reset();
        r("p0 latch", PIO_ADDR_P0_DATA, 1'b1, PIO_RST_DATA);
        r("p0 otype", PIO_ADDR_P0_OTYPE, 1'b0, 8'h00);
        r("p0 bypass", PIO_ADDR_P0_BYPASS, 1'b0, PIO_RST_BYPASS);
        r("p0 asel", PIO_ADDR_P0_ASEL, 1'b0, PIO_RST_ASEL);
        r("unmapped", 8'h00, 1'b0, 8'h00);
        chk("p0 oe", p0_oe, 8'h00);
        chk("p0 pull", p0_pu, 8'hff);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_gpio();
        w(PIO_ADDR_XBAR_CTL, 8'h40);
        chk("xbar en", {7'h00, xbar}, 8'h01);
        r("xbar ctl", PIO_ADDR_XBAR_CTL, 1'b0, 8'h40);
        w(PIO_ADDR_P0_OTYPE, 8'h0f);
        w(PIO_ADDR_P0_DATA, 8'ha5);
        chk("p0 out", p0_out, 8'ha5);
        chk("p0 oe", p0_oe, 8'h5f);
        r("p0 latch", PIO_ADDR_P0_DATA, 1'b1, 8'ha5);
        settle();
        r("p0 pins", PIO_ADDR_P0_DATA, 1'b0, 8'ha5);
        @(posedge clk_sys);
        ext_oe <= 8'h80;
        settle();
        r("p0 pins", PIO_ADDR_P0_DATA, 1'b0, 8'h25);
        r("p0 latch", PIO_ADDR_P0_DATA, 1'b1, 8'ha5);
        acc(1'b0, PIO_ADDR_P0_DATA, 8'h00, 1'b1, 3'h7, 1'b0);
        chk("p0 bit7", sfr_rdata, 8'h00);
        acc(1'b1, PIO_ADDR_P0_DATA, 8'h00, 1'b1, 3'h0, 1'b1);
        r("p0 latch", PIO_ADDR_P0_DATA, 1'b1, 8'ha4);
        acc(1'b1, PIO_ADDR_P0_DATA, 8'h5b, 1'b0, 3'h0, 1'b1);
        chk("p0 out", p0_out, 8'h5b);
        $display("t_gpio done");
    endtask : t_gpio
    task automatic t_periph();
        @(posedge clk_sys);
        {own, poe, pout} <= {8'h40, 8'h40, 8'h00};
        settle();
        r("p0 pins", PIO_ADDR_P0_DATA, 1'b0, 8'h1b);
        r("p0 latch", PIO_ADDR_P0_DATA, 1'b1, 8'h5b);
        @(posedge clk_sys);
        {own, poe} <= 16'h0000;
        w(PIO_ADDR_P0_ASEL, 8'hf0);
        chk("p0 oe", p0_oe & 8'h0f, 8'h00);
        chk("p0 pull", p0_pu, 8'hf0);
        chk("p0 analog", p0_an, 8'hf0);
        settle();
        r("p0 pins", PIO_ADDR_P0_DATA, 1'b0, 8'h5f);
        w(PIO_ADDR_P0_ASEL, 8'hff);
        $display("t_periph done");
    endtask : t_periph
    task automatic t_port1();
        w(PIO_ADDR_P1_OTYPE, 8'h00);
        w(PIO_ADDR_P1_DATA, 8'h3c);
        chk("p1 oe", p1_oe, 8'hc3);
        chk("p1 out", p1_out, 8'h3c);
        w(PIO_ADDR_P1_ASEL, 8'h0f);
        chk("p1 asel", p1_an, 8'h0f);
        chk("p1 pull", p1_pu, 8'h0f);
        settle();
        r("p1 pins", PIO_ADDR_P1_DATA, 1'b0, 8'hfc);
        w(PIO_ADDR_P0_BYPASS, 8'h81);
        chk("p0 skip", p0_skip, 8'h81);
        w(PIO_ADDR_XBAR_CTL, 8'h00);
        chk("all oe", p0_oe | p1_oe, 8'h00);
        @(posedge clk_sys);
        ext_val <= 8'h80;
        settle();
        r("p0 ext", PIO_ADDR_P0_DATA, 1'b0, 8'hff);
        $display("t_port1 done");
    endtask : t_port1
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_gpio();
        t_periph();
        t_port1();
        stop_test();
    end
endmodule : pio_port_io_tb
`default_nettype wire
